// >>> hw/address_arithmetic_units.sv
// Purpose: Program and data address generation for the signal processor core
// Assumes: Commands, register transfers and ISR flag come from core logic
// Notes:   Register reads answer one cycle after the request
`timescale 1ns/100ps

module address_arithmetic_units #(
  parameter int DW = address_units_pkg::DATA_W_WIDE
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         isr_active_i,
  input  wire address_units_pkg::prog_cmd_t prog_cmd_i,
  input  wire address_units_pkg::data_cmd_t data_cmd_i,
  input  wire address_units_pkg::reg_xfer_t xfer_i,
  output logic [15:0]                       pc_o,
  output logic [15:0]                       table_addr_o,
  output logic [15:0]                       call_link_o,
  output logic [15:0]                       isr_shadow_address_o,
  output logic [3:0][DW-1:0]                data_memory_cursors_o,
  output logic [DW-1:0]                     ring_end_o,
  output address_units_pkg::rd_resp_t       rd_resp_o,
  output logic                              prng_reset_o
);

  // ----------------------------------------------------------------
  // Program address unit state
  // ----------------------------------------------------------------
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic        pc_load;
  logic [15:0] call_link_reg;
  logic [15:0] isr_shadow_address_reg;
  logic [15:0] table_cursor_reg;
  logic [11:0] offset_reg;
  logic [11:0] tbl_low_sum;
  logic [15:0] return_addr;
  logic        is_call;
  logic        shadow_wr;
  logic        link_wr;
  logic        table_wr;
  logic        prng_reset_reg;
  logic [15:0] prog_rd_value;
  logic [15:0] data_rd_value;
  address_units_pkg::rd_resp_t rd_resp_reg;

  // Return address is the word after the call
  assign return_addr = pc_reg + address_units_pkg::PC_ONE;
  assign is_call     = (prog_cmd_i.src == address_units_pkg::PC_CALL)
                       || (prog_cmd_i.src == address_units_pkg::PC_CALL_TBL);
  assign shadow_wr   = xfer_i.wr_en && (xfer_i.id == address_units_pkg::REG_SHADOW);

  // Register load strobes
  assign link_wr     = xfer_i.wr_en && (xfer_i.id == address_units_pkg::REG_CALL_LINK);
  assign table_wr    = xfer_i.wr_en && (xfer_i.id == address_units_pkg::REG_TABLE);

  // PC source select
  always_comb begin
    pc_next = pc_reg;
    pc_load = 1'b1;
    unique case (prog_cmd_i.src)
      address_units_pkg::PC_HOLD: begin
        pc_load = 1'b0;
      end
      address_units_pkg::PC_STEP:     pc_next = return_addr;
      address_units_pkg::PC_JUMP:     pc_next = prog_cmd_i.target;
      address_units_pkg::PC_CALL:     pc_next = prog_cmd_i.target;
      address_units_pkg::PC_RETURN:   pc_next = call_link_reg;
      address_units_pkg::PC_IRETURN:  pc_next = isr_shadow_address_reg;
      address_units_pkg::PC_JUMP_TBL: pc_next = table_cursor_reg;
      address_units_pkg::PC_CALL_TBL: pc_next = table_cursor_reg;
      default: ;
    endcase
  end

  // Program counter
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pc_reg <= address_units_pkg::PC_RST;
    end else if (pc_load) begin
      pc_reg <= pc_next;
    end
  end

  // Call link: a call outranks a same-cycle load
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      call_link_reg <= address_units_pkg::PTR_RST;
    end else if (is_call) begin
      call_link_reg <= return_addr;
    end else if (link_wr) begin
      call_link_reg <= xfer_i.data;
    end
  end

  // Shadow: tracks PC outside service, writable only inside service
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      isr_shadow_address_reg <= address_units_pkg::PTR_RST;
    end else if (!isr_active_i && pc_load) begin
      isr_shadow_address_reg <= pc_next;
    end else if (isr_active_i && shadow_wr) begin
      isr_shadow_address_reg <= xfer_i.data;
    end
  end

  // PRNG reset pulse on a shadow write outside service
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prng_reset_reg <= 1'b0;
    end else begin
      prng_reset_reg <= shadow_wr && !isr_active_i;
    end
  end

  // ----------------------------------------------------------------
  // Table cursor and offset
  // ----------------------------------------------------------------
  // 12-bit adder: only the in-page bits move
  assign tbl_low_sum = table_cursor_reg[address_units_pkg::PAGE_LSB-1:0]
                     + ((prog_cmd_i.tbl_mod == address_units_pkg::TBL_OFS) ? offset_reg
                                                                          : address_units_pkg::TBL_ONE);

  // Load outranks post-modification of the table cursor
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      table_cursor_reg <= address_units_pkg::PTR_RST;
    end else if (table_wr) begin
      table_cursor_reg <= xfer_i.data;
    end else if (prog_cmd_i.tbl_mod != address_units_pkg::TBL_KEEP) begin
      table_cursor_reg <= {table_cursor_reg[15:address_units_pkg::PAGE_LSB], tbl_low_sum};
    end
  end

  // Offset register keeps the low 12 bits of a load
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      offset_reg <= address_units_pkg::OFS_RST;
    end else if (xfer_i.wr_en && xfer_i.id == address_units_pkg::REG_OFFSET) begin
      offset_reg <= xfer_i.data[address_units_pkg::OFS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Data address unit
  // ----------------------------------------------------------------
  data_address_unit #(
    .DW (DW)
  ) u_data_address_unit (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .cmd_i      (data_cmd_i),
    .xfer_i     (xfer_i),
    .cursor_o   (data_memory_cursors_o),
    .ring_end_o (ring_end_o),
    .rd_value_o (data_rd_value)
  );

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  always_comb begin
    prog_rd_value = 16'h0000;
    unique case (xfer_i.id)
      address_units_pkg::REG_CALL_LINK: prog_rd_value = call_link_reg;
      address_units_pkg::REG_SHADOW:    prog_rd_value = isr_shadow_address_reg;
      address_units_pkg::REG_TABLE:     prog_rd_value = table_cursor_reg;
      address_units_pkg::REG_OFFSET:    prog_rd_value = 16'(signed'(offset_reg));
      default: ;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_resp_reg <= '0;
    end else begin
      rd_resp_reg.valid <= xfer_i.rd_en;
      if (xfer_i.rd_en) begin
        rd_resp_reg.data <= address_units_pkg::is_data_reg(xfer_i.id) ? data_rd_value
                                                                       : prog_rd_value;
      end
    end
  end

  // Outputs straight from flops; pointer outputs are pre-modification values
  assign pc_o                 = pc_reg;
  assign table_addr_o         = table_cursor_reg;
  assign call_link_o          = call_link_reg;
  assign isr_shadow_address_o = isr_shadow_address_reg;
  assign rd_resp_o            = rd_resp_reg;
  assign prng_reset_o         = prng_reset_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence call_s;
    prog_cmd_i.src == address_units_pkg::PC_CALL;
  endsequence

  sequence return_s;
    prog_cmd_i.src == address_units_pkg::PC_RETURN && !is_call && !link_wr;
  endsequence

  sequence step_s;
    prog_cmd_i.src == address_units_pkg::PC_STEP;
  endsequence

  sequence tbl_call_s;
    prog_cmd_i.src == address_units_pkg::PC_CALL_TBL;
  endsequence

  call_link_save_a: assert property (call_s |=> call_link_reg == $past(pc_reg) + 16'h0001)
    else $error("call did not save return address");

  call_return_a: assert property (call_s ##1 return_s |=> pc_reg == $past(pc_reg, 2) + 16'h0001)
    else $error("return did not reach call site plus one");

  iret_load_a: assert property (prog_cmd_i.src == address_units_pkg::PC_IRETURN
    |=> pc_reg == $past(isr_shadow_address_reg))
    else $error("interrupt return missed shadow");

  tbl_jump_a: assert property (prog_cmd_i.src inside {address_units_pkg::PC_JUMP_TBL,
    address_units_pkg::PC_CALL_TBL} |=> pc_reg == $past(table_cursor_reg))
    else $error("jump via table cursor wrong");

  tbl_link_a: assert property (tbl_call_s |=> call_link_reg == $past(pc_reg) + 16'h0001)
    else $error("table call lost return");

  pc_step_a: assert property (step_s |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("pc step wrong");

  pc_hold_a: assert property (!pc_load |=> $stable(pc_reg))
    else $error("pc moved on hold");

  page_keep_a: assert property (prog_cmd_i.tbl_mod != address_units_pkg::TBL_KEEP && !table_wr
    |=> table_cursor_reg[15:12] == $past(table_cursor_reg[15:12]))
    else $error("post-modify changed page bits");

  tbl_ofs_a: assert property (prog_cmd_i.tbl_mod == address_units_pkg::TBL_OFS && !xfer_i.wr_en
    |=> table_cursor_reg[11:0] == 12'($past(table_cursor_reg[11:0]) + $past(offset_reg)))
    else $error("offset post-modify wrong");

  tbl_inc_a: assert property (prog_cmd_i.tbl_mod == address_units_pkg::TBL_INC && !table_wr
    |=> table_cursor_reg[11:0] == $past(table_cursor_reg[11:0]) + 12'h001)
    else $error("table increment wrong");

  tbl_hold_a: assert property (prog_cmd_i.tbl_mod == address_units_pkg::TBL_KEEP && !table_wr
    |=> $stable(table_cursor_reg))
    else $error("table cursor moved");

  table_load_a: assert property (table_wr |=> table_cursor_reg == $past(xfer_i.data))
    else $error("table load lost");

  link_load_a: assert property (link_wr && !is_call |=> call_link_reg == $past(xfer_i.data))
    else $error("link load lost");

  link_hold_a: assert property (!is_call && !link_wr |=> $stable(call_link_reg))
    else $error("link moved");

  shadow_copy_a: assert property (!isr_active_i && pc_load |=> isr_shadow_address_reg == pc_reg)
    else $error("shadow not copied from pc");

  shadow_hold_a: assert property (isr_active_i && !shadow_wr |=> $stable(isr_shadow_address_reg))
    else $error("shadow moved during service");

  shadow_load_a: assert property (isr_active_i && shadow_wr
    |=> isr_shadow_address_reg == $past(xfer_i.data))
    else $error("shadow write lost");

  prng_pulse_a: assert property (shadow_wr && !isr_active_i && !pc_load
    |=> prng_reset_o && $stable(isr_shadow_address_reg))
    else $error("shadow write outside service misbehaved");

  prng_quiet_a: assert property (!(shadow_wr && !isr_active_i) |=> !prng_reset_o)
    else $error("stray generator reset");

  offset_read_a: assert property (xfer_i.rd_en && xfer_i.id == address_units_pkg::REG_OFFSET
    |=> rd_resp_o.valid && rd_resp_o.data == {{4{$past(offset_reg[11])}}, $past(offset_reg)})
    else $error("offset read not sign-extended");

  rd_pulse_a: assert property (xfer_i.rd_en |=> rd_resp_o.valid)
    else $error("read not answered");

  rd_idle_a: assert property (!xfer_i.rd_en |=> !rd_resp_o.valid)
    else $error("stray read answer");

endmodule : address_arithmetic_units

// >>> pkg/address_units_pkg.sv
// Purpose: Shared constants, types and decoders for the address arithmetic units
// Assumes: One core clock, synchronous active-high reset
// Notes:   Register selectors cover both program-side and data-side registers
package address_units_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          PC_W          = 16;
  localparam int          OFS_W         = 12;
  localparam int          PAGE_LSB      = 12;
  localparam int          BUS_W         = 16;
  localparam int          DATA_W_WIDE   = 16;
  localparam int          DATA_W_NARROW = 9;
  localparam int          CURSOR_CNT    = 4;
  localparam logic [15:0] PC_RST        = 16'h0000;
  localparam logic [15:0] PTR_RST       = 16'h0000;
  localparam logic [11:0] OFS_RST       = 12'h000;
  localparam logic [15:0] RING_END_RST  = 16'h0000;
  localparam logic [15:0] PC_ONE        = 16'h0001;
  localparam logic [11:0] TBL_ONE       = 12'h001;

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PC_HOLD     = 3'b000,
    PC_STEP     = 3'b001,
    PC_JUMP     = 3'b011,
    PC_CALL     = 3'b010,
    PC_RETURN   = 3'b110,
    PC_IRETURN  = 3'b111,
    PC_JUMP_TBL = 3'b101,
    PC_CALL_TBL = 3'b100
  } pc_src_t;

  typedef enum logic [1:0] {
    TBL_KEEP = 2'b00,
    TBL_INC  = 2'b01,
    TBL_OFS  = 2'b10
  } tbl_mod_t;

  typedef enum logic [2:0] {
    STEP_ZERO = 3'b000,
    STEP_INC  = 3'b001,
    STEP_DEC  = 3'b010,
    STEP_TWO  = 3'b011,
    STEP_J    = 3'b100,
    STEP_K    = 3'b101
  } step_t;

  typedef enum logic [3:0] {
    REG_CALL_LINK  = 4'h0,
    REG_SHADOW     = 4'h1,
    REG_TABLE      = 4'h2,
    REG_OFFSET     = 4'h3,
    REG_CURSOR0    = 4'h4,
    REG_CURSOR1    = 4'h5,
    REG_CURSOR2    = 4'h6,
    REG_CURSOR3    = 4'h7,
    REG_RING_START = 4'h8,
    REG_RING_END   = 4'h9,
    REG_STEP_J     = 4'ha,
    REG_STEP_K     = 4'hb
  } reg_id_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    reg_id_t     id;
    logic [15:0] data;
  } reg_xfer_t;

  typedef struct packed {
    pc_src_t     src;
    logic [15:0] target;
    tbl_mod_t    tbl_mod;
  } prog_cmd_t;

  typedef struct packed {
    logic        access;
    logic [1:0]  cursor;
    step_t       step;
  } data_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } rd_resp_t;

  // Data-side selector decode
  function automatic logic is_data_reg(input reg_id_t id);
    is_data_reg = (id >= REG_CURSOR0) && (id <= REG_STEP_K);
  endfunction : is_data_reg

endpackage : address_units_pkg

// >>> hw/data_address_unit.sv
// Purpose: Data memory cursors, step registers and ring bounds
// Assumes: Commands come from logic on the same clock
// Notes:   Cursor outputs are the flops; the read value is combinational
`timescale 1ns/100ps
module data_address_unit #(
  parameter int DW = address_units_pkg::DATA_W_WIDE
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire address_units_pkg::data_cmd_t cmd_i,
  input  wire address_units_pkg::reg_xfer_t xfer_i,
  output logic [3:0][DW-1:0]                cursor_o,
  output logic [DW-1:0]                     ring_end_o,
  output logic [15:0]                       rd_value_o
);

  localparam logic [DW-1:0] ONE  = DW'(1);
  localparam logic [DW-1:0] TWO  = DW'(2);
  localparam logic [DW-1:0] ZERO = '0;

  logic [3:0][DW-1:0] cursor_reg;
  logic [DW-1:0]      ring_start_reg;
  logic [DW-1:0]      ring_end_reg;
  logic [DW-1:0]      step_j_reg;
  logic [DW-1:0]      step_k_reg;
  logic [DW-1:0]      step_val;
  logic [DW-1:0]      sel_cursor;
  logic               wrap;

  // ----------------------------------------------------------------
  // Post-modification amount and ring wrap
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cmd_i.step)
      address_units_pkg::STEP_INC: step_val = ONE;
      address_units_pkg::STEP_DEC: step_val = '1;
      address_units_pkg::STEP_TWO: step_val = TWO;
      address_units_pkg::STEP_J:   step_val = step_j_reg;
      address_units_pkg::STEP_K:   step_val = step_k_reg;
      default:                     step_val = ZERO;
    endcase
  end

  // Wrap on last ring entry with unit increment, never when end is zero
  assign sel_cursor = cursor_reg[cmd_i.cursor];
  assign wrap = (ring_end_reg != ZERO) && (sel_cursor == ring_end_reg)
                && (cmd_i.step == address_units_pkg::STEP_INC);

  // ----------------------------------------------------------------
  // Cursors: explicit load wins over post-modification
  // ----------------------------------------------------------------
  for (genvar g = 0; g < address_units_pkg::CURSOR_CNT; g++) begin : g_cursor
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
        cursor_reg[g] <= ZERO;
      end else if (xfer_i.wr_en && xfer_i.id == address_units_pkg::reg_id_t'(4 + g)) begin
        cursor_reg[g] <= xfer_i.data[DW-1:0];
      end else if (cmd_i.access && cmd_i.cursor == 2'(g)) begin
        cursor_reg[g] <= wrap ? ring_start_reg : cursor_reg[g] + step_val;
      end
    end
  end

  // Ring bounds and step registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ring_start_reg <= ZERO;
      ring_end_reg   <= address_units_pkg::RING_END_RST[DW-1:0];
      step_j_reg     <= ZERO;
      step_k_reg     <= ZERO;
    end else if (xfer_i.wr_en) begin
      unique case (xfer_i.id)
        address_units_pkg::REG_RING_START: ring_start_reg <= xfer_i.data[DW-1:0];
        address_units_pkg::REG_RING_END:   ring_end_reg   <= xfer_i.data[DW-1:0];
        address_units_pkg::REG_STEP_J:     step_j_reg     <= xfer_i.data[DW-1:0];
        address_units_pkg::REG_STEP_K:     step_k_reg     <= xfer_i.data[DW-1:0];
        default: ;
      endcase
    end
  end

  // Read mux: steps sign-extend, addresses zero-extend
  always_comb begin
    rd_value_o = 16'h0000;
    unique case (xfer_i.id)
      address_units_pkg::REG_CURSOR0:    rd_value_o = 16'(cursor_reg[0]);
      address_units_pkg::REG_CURSOR1:    rd_value_o = 16'(cursor_reg[1]);
      address_units_pkg::REG_CURSOR2:    rd_value_o = 16'(cursor_reg[2]);
      address_units_pkg::REG_CURSOR3:    rd_value_o = 16'(cursor_reg[3]);
      address_units_pkg::REG_RING_START: rd_value_o = 16'(ring_start_reg);
      address_units_pkg::REG_RING_END:   rd_value_o = 16'(ring_end_reg);
      address_units_pkg::REG_STEP_J:     rd_value_o = 16'(signed'(step_j_reg));
      address_units_pkg::REG_STEP_K:     rd_value_o = 16'(signed'(step_k_reg));
      default: ;
    endcase
  end

  assign cursor_o   = cursor_reg;
  assign ring_end_o = ring_end_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  ring_wrap_a: assert property (cmd_i.access && wrap && !xfer_i.wr_en
    |=> cursor_reg[$past(cmd_i.cursor)] == $past(ring_start_reg))
    else $error("ring wrap did not load ring start");
  ring_off_a: assert property (cmd_i.access && ring_end_reg == ZERO && !xfer_i.wr_en
    |=> cursor_reg[$past(cmd_i.cursor)] == $past(sel_cursor) + $past(step_val))
    else $error("ring wrap taken with end at zero");
  ring_reset_a: assert property (@(posedge sys_clk_i) disable iff (1'b0)
    sys_rst_i |=> ring_end_reg == ZERO)
    else $error("ring end not cleared by reset");
  step_dec_a: assert property (cmd_i.access && cmd_i.step == address_units_pkg::STEP_DEC
    && !xfer_i.wr_en |=> cursor_reg[$past(cmd_i.cursor)] == $past(sel_cursor) - ONE)
    else $error("cursor decrement wrong");

endmodule : data_address_unit

// >>> verif/data_ram_model.sv
// Purpose: Far-side data memory stand-in that logs access addresses
// Assumes: Cursor outputs are the flops holding the current address
// Notes:   Only the address of each access is kept, no data
`timescale 1ns/100ps
module data_ram_model #(
  parameter int DW = 16
) (
  input  wire logic               sys_clk_i,
  input  wire logic               access_i,
  input  wire logic [1:0]         cursor_i,
  input  wire logic [3:0][DW-1:0] cursors_i,
  output logic      [DW-1:0]      last_addr_o
);
  // Pre-update cursor is the address of this access
  always_ff @(posedge sys_clk_i) begin
    if (access_i) begin
      last_addr_o <= cursors_i[cursor_i];
    end
  end
endmodule : data_ram_model

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the address arithmetic units
// Assumes: Wide variant, inputs driven on the falling edge
// Notes:   Register rows first, then call, interrupt, table and ring cases
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic                          sys_clk_i;
  logic                          sys_rst_i;
  logic                          isr_active_i;
  address_units_pkg::prog_cmd_t  prog_cmd_i;
  address_units_pkg::data_cmd_t  data_cmd_i;
  address_units_pkg::reg_xfer_t  xfer_i;
  logic [15:0]                   pc_o, table_addr_o, call_link_o, isr_shadow_address_o;
  logic [3:0][15:0]              data_memory_cursors_o;
  logic [15:0]                   ring_end_o, last_addr, prev;
  address_units_pkg::rd_resp_t   rd_resp_o;
  logic                          prng_reset_o;
  int                            errors, total_checks;
  typedef struct packed {address_units_pkg::reg_id_t id; logic [15:0] wv; logic [15:0] rv;} row_t;
  row_t rows [9] = '{'{address_units_pkg::REG_CALL_LINK, 16'h1111, 16'h1111},
    '{address_units_pkg::REG_TABLE, 16'h2222, 16'h2222}, '{address_units_pkg::REG_OFFSET, 16'h0800, 16'hf800},
    '{address_units_pkg::REG_CURSOR1, 16'h0101, 16'h0101}, '{address_units_pkg::REG_CURSOR3, 16'hffff, 16'hffff},
    '{address_units_pkg::REG_RING_START, 16'h07ff, 16'h07ff}, '{address_units_pkg::REG_STEP_J, 16'h8000, 16'h8000},
    '{address_units_pkg::REG_STEP_K, 16'h7fff, 16'h7fff}, '{address_units_pkg::reg_id_t'(4'hc), 16'h1234, 16'h0000}};
  logic [2:0]  stp [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h1};
  logic [15:0] cex [7] = '{16'h0010, 16'h000f, 16'h0011, 16'h0016, 16'h0015, 16'h0015, 16'h0016};

  address_arithmetic_units #(.DW(16)) i_address_arithmetic_units (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .isr_active_i(isr_active_i), .prog_cmd_i(prog_cmd_i), .data_cmd_i(data_cmd_i), .xfer_i(xfer_i), .pc_o(pc_o),
    .table_addr_o(table_addr_o), .call_link_o(call_link_o), .isr_shadow_address_o(isr_shadow_address_o),
    .data_memory_cursors_o(data_memory_cursors_o), .ring_end_o(ring_end_o), .rd_resp_o(rd_resp_o),
    .prng_reset_o(prng_reset_o));
  data_ram_model #(.DW(16)) i_data_ram_model (.sys_clk_i(sys_clk_i), .access_i(data_cmd_i.access),
    .cursor_i(data_cmd_i.cursor), .cursors_i(data_memory_cursors_o), .last_addr_o(last_addr));

  // ----------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Drivers: one active cycle, then idle
  // ----------------------------------------------------------------
  task automatic go(input address_units_pkg::prog_cmd_t p, input address_units_pkg::data_cmd_t d,
                    input address_units_pkg::reg_xfer_t x);
    @(negedge sys_clk_i);
    prog_cmd_i = p;
    data_cmd_i = d;
    xfer_i = x;
    @(negedge sys_clk_i);
    prog_cmd_i = '0;
    data_cmd_i = '0;
    xfer_i = '0;
  endtask : go
  task automatic wr(input address_units_pkg::reg_id_t id, input logic [15:0] v);
    go('0, '0, '{1'b1, 1'b0, id, v});
  endtask : wr
  task automatic rd(input address_units_pkg::reg_id_t id, input logic [15:0] e);
    go('0, '0, '{1'b0, 1'b1, id, 16'h0000});
    `CHK("rd_valid", 1'b1, rd_resp_o.valid)
    `CHK("rd_data", e, rd_resp_o.data)
  endtask : rd
  task automatic pcg(input address_units_pkg::pc_src_t s, input logic [15:0] t, input address_units_pkg::tbl_mod_t m);
    go('{s, t, m}, '0, '0);
  endtask : pcg

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1; isr_active_i = 1'b0; prog_cmd_i = '0; data_cmd_i = '0; xfer_i = '0;
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    `CHK("ring_end_rst", 16'h0000, ring_end_o)
    // Register rows: load, then read back
    foreach (rows[i]) begin
      wr(rows[i].id, rows[i].wv);
      rd(rows[i].id, rows[i].rv);
    end
    // Call, return and shadow copy
    pcg(address_units_pkg::PC_JUMP, 16'h0100, address_units_pkg::TBL_KEEP);
    pcg(address_units_pkg::PC_CALL, 16'h0200, address_units_pkg::TBL_KEEP);
    `CHK("call_link", 16'h0101, call_link_o)
    `CHK("shadow", 16'h0200, isr_shadow_address_o)
    pcg(address_units_pkg::PC_RETURN, 16'h0000, address_units_pkg::TBL_KEEP);
    `CHK("pc_ret", 16'h0101, pc_o)
    // Interrupt service: shadow frozen, writable
    isr_active_i = 1'b1;
    pcg(address_units_pkg::PC_JUMP, 16'h0300, address_units_pkg::TBL_KEEP);
    `CHK("shadow_isr", 16'h0101, isr_shadow_address_o)
    wr(address_units_pkg::REG_SHADOW, 16'h0555);
    `CHK("shadow_wr", 16'h0555, isr_shadow_address_o)
    `CHK("prng_isr", 1'b0, prng_reset_o)
    pcg(address_units_pkg::PC_IRETURN, 16'h0000, address_units_pkg::TBL_KEEP);
    `CHK("pc_iret", 16'h0555, pc_o)
    isr_active_i = 1'b0;
    wr(address_units_pkg::REG_SHADOW, 16'h0777);
    `CHK("prng_reset", 1'b1, prng_reset_o)
    `CHK("shadow_kept", 16'h0555, isr_shadow_address_o)
    // Table cursor post-modify within a page
    wr(address_units_pkg::REG_TABLE, 16'h2fff);
    wr(address_units_pkg::REG_OFFSET, 16'h0ffe);
    pcg(address_units_pkg::PC_HOLD, 16'h0000, address_units_pkg::TBL_INC);
    `CHK("tbl_inc", 16'h2000, table_addr_o)
    pcg(address_units_pkg::PC_HOLD, 16'h0000, address_units_pkg::TBL_OFS);
    `CHK("tbl_ofs", 16'h2ffe, table_addr_o)
    pcg(address_units_pkg::PC_JUMP_TBL, 16'h0000, address_units_pkg::TBL_KEEP);
    `CHK("pc_tbl", 16'h2ffe, pc_o)
    pcg(address_units_pkg::PC_CALL_TBL, 16'h0000, address_units_pkg::TBL_KEEP);
    `CHK("call_tbl", 16'h2fff, call_link_o)
    pcg(address_units_pkg::PC_STEP, 16'h0000, address_units_pkg::TBL_KEEP);
    `CHK("pc_step", 16'h2fff, pc_o)
    // Call and return on consecutive edges
    @(negedge sys_clk_i) prog_cmd_i = '{address_units_pkg::PC_CALL, 16'h0400, address_units_pkg::TBL_KEEP};
    @(negedge sys_clk_i) prog_cmd_i.src = address_units_pkg::PC_RETURN;
    @(negedge sys_clk_i) prog_cmd_i = '0;
    `CHK("pc_b2b", 16'h3000, pc_o)
    // Cursor steps with ring wrap
    wr(address_units_pkg::REG_RING_START, 16'h0010);
    wr(address_units_pkg::REG_RING_END, 16'h0013);
    wr(address_units_pkg::REG_CURSOR0, 16'h0013);
    wr(address_units_pkg::REG_STEP_J, 16'h0005);
    wr(address_units_pkg::REG_STEP_K, 16'hffff);
    foreach (stp[i]) begin
      prev = data_memory_cursors_o[0];
      go('0, '{1'b1, 2'd0, address_units_pkg::step_t'(stp[i])}, '0);
      `CHK("cursor0", cex[i], data_memory_cursors_o[0])
      `CHK("access_addr", prev, last_addr)
    end
    // Mid-run reset, then a full-size ring
    @(negedge sys_clk_i) sys_rst_i = 1'b1;
    @(negedge sys_clk_i) sys_rst_i = 1'b0;
    `CHK("ring_end_rst2", 16'h0000, ring_end_o)
    `CHK("cursor0_rst", 16'h0000, data_memory_cursors_o[0])
    wr(address_units_pkg::REG_RING_END, 16'h07ff);
    wr(address_units_pkg::REG_CURSOR2, 16'h07ff);
    go('0, '{1'b1, 2'd2, address_units_pkg::STEP_INC}, '0);
    `CHK("ring_2k", 16'h0000, data_memory_cursors_o[2])
    // Ring end zero disables wrap
    wr(address_units_pkg::REG_RING_END, 16'h0000);
    wr(address_units_pkg::REG_CURSOR1, 16'h0000);
    go('0, '{1'b1, 2'd1, address_units_pkg::STEP_INC}, '0);
    `CHK("cursor1", 16'h0001, data_memory_cursors_o[1])
    report_and_stop();
  end
endmodule : tb_top
